// ### fsw_pkg.sv
// shared constants and types for the file-minus-working-register unit
package fsw_pkg;

  localparam int unsigned DATA_W      = 8;
  localparam int unsigned INSTR_W     = 16;
  localparam int unsigned FADDR_W     = 8;
  localparam int unsigned BANK_W      = 4;
  localparam int unsigned LIN_ADDR_W  = FADDR_W + BANK_W;
  localparam int unsigned APB_ADDR_W  = 8;
  localparam int unsigned APB_DATA_W  = 32;
  localparam int unsigned OPC_W       = 6;
  localparam int unsigned FLAG_W      = 5;

  // instruction word layout
  localparam int unsigned OPC_HI      = 15;
  localparam int unsigned OPC_LO      = 10;
  localparam int unsigned DEST_BIT    = 9;
  localparam int unsigned ACCESS_BIT  = 8;
  localparam int unsigned FADDR_HI    = 7;
  localparam int unsigned FADDR_LO    = 0;

  localparam logic [OPC_W-1:0] OPC_FILE_MINUS_ACC = 6'h17;
  localparam logic             DEST_WORK          = 1'h0;
  localparam logic             ACCESS_FIXED       = 1'h0;

  // fixed access bank: low half of bank 0, high half of the top bank
  localparam logic [FADDR_W-1:0] ACCESS_SPLIT     = 8'h80;
  localparam logic [BANK_W-1:0]  ACCESS_LOW_BANK  = 4'h0;
  localparam logic [BANK_W-1:0]  ACCESS_HIGH_BANK = 4'hf;

  // register map, byte addresses
  localparam logic [APB_ADDR_W-1:0] OFS_INSTR     = 8'h00;
  localparam logic [APB_ADDR_W-1:0] OFS_WORK      = 8'h04;
  localparam logic [APB_ADDR_W-1:0] OFS_BANK      = 8'h08;
  localparam logic [APB_ADDR_W-1:0] OFS_STATUS    = 8'h0c;
  localparam logic [APB_ADDR_W-1:0] OFS_FILE_ADDR = 8'h10;
  localparam logic [APB_ADDR_W-1:0] OFS_FILE_DATA = 8'h14;
  localparam logic [APB_ADDR_W-1:0] OFS_RESULT    = 8'h18;

  // status register bit positions
  localparam int unsigned ST_CARRY   = 0;
  localparam int unsigned ST_NIBBLE  = 1;
  localparam int unsigned ST_ZERO    = 2;
  localparam int unsigned ST_WRAP    = 3;
  localparam int unsigned ST_NEG     = 4;
  localparam int unsigned ST_BUSY    = 5;
  localparam int unsigned ST_ILLEGAL = 6;

  localparam logic [DATA_W-1:0]     WORK_RST   = 8'h00;
  localparam logic [BANK_W-1:0]     BANK_RST   = 4'h0;
  localparam logic [FLAG_W-1:0]     FLAGS_RST  = 5'h00;
  localparam logic [INSTR_W-1:0]    INSTR_RST  = 16'h0000;
  localparam logic [LIN_ADDR_W-1:0] FADDR_RST  = 12'h000;
  localparam logic [APB_DATA_W-1:0] PRDATA_RST = 32'h0000_0000;

  // one instruction cycle: decode, read, process, write
  typedef enum logic [4:0] {
    S_IDLE   = 5'b00001,
    S_DECODE = 5'b00010,
    S_READ   = 5'b00100,
    S_PROC   = 5'b01000,
    S_WRITE  = 5'b10000
  } fsw_state_e;

endpackage : fsw_pkg

// ### fsw_if.sv
// carriers between the core, the subtractor and the file memory
`timescale 1ns/100ps
interface fsw_alu_if;
  import fsw_pkg::*;
  logic [DATA_W-1:0] file_val;
  logic [DATA_W-1:0] work_val;
  logic [DATA_W-1:0] result;
  logic [FLAG_W-1:0] flags;
  modport core (output file_val, output work_val, input result, input flags);
  modport alu  (input file_val, input work_val, output result, output flags);
endinterface : fsw_alu_if

interface fsw_mem_if;
  import fsw_pkg::*;
  logic                  we;
  logic [LIN_ADDR_W-1:0] waddr;
  logic [DATA_W-1:0]     wdata;
  logic [LIN_ADDR_W-1:0] raddr;
  logic [DATA_W-1:0]     rdata;
  modport core (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : fsw_mem_if

// ### fsw_alu.sv
// two's complement subtractor: file value minus working value, with flags
`timescale 1ns/100ps
module fsw_alu
  import fsw_pkg::*;
(
  fsw_alu_if.alu bus
);

  logic [DATA_W:0]   diff;
  logic [4:0]        low_diff;
  logic [DATA_W-1:0] res;

  always_comb begin
    // add the inverse plus one so bit 8 is carry, i.e. set when no borrow
    diff     = {1'b0, bus.file_val} + {1'b0, ~bus.work_val} + 9'h001;
    low_diff = {1'b0, bus.file_val[3:0]} + {1'b0, ~bus.work_val[3:0]} + 5'h01;
    res      = diff[DATA_W-1:0];
    bus.result               = res;
    bus.flags                = FLAGS_RST;
    bus.flags[ST_CARRY]      = diff[DATA_W];
    bus.flags[ST_NIBBLE]     = low_diff[4];
    bus.flags[ST_ZERO]       = (res == 8'h00);
    bus.flags[ST_NEG]        = res[DATA_W-1];
    bus.flags[ST_WRAP]       = (bus.file_val[DATA_W-1] != bus.work_val[DATA_W-1]) &&
                               (res[DATA_W-1] != bus.file_val[DATA_W-1]);
  end

endmodule : fsw_alu

// ### fsw_mem.sv
// banked data memory with one write port and a registered read port
`timescale 1ns/100ps
module fsw_mem
  import fsw_pkg::*;
#(
  parameter int unsigned ADDR_W = LIN_ADDR_W,
  parameter int unsigned WORD_W = DATA_W
) (
  input  wire logic CORE_CLK,
  input  wire logic RESET,
  fsw_mem_if.mem    bus
);

  logic [WORD_W-1:0] store [0:(1<<ADDR_W)-1];
  logic [WORD_W-1:0] rdata_q;
  logic [WORD_W-1:0] rdata_d;

  // read before write: a same-cycle write is seen one cycle later
  always_comb begin
    rdata_d = store[bus.raddr];
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // the array itself has no reset; contents are undefined until written
  always_ff @(posedge CORE_CLK) begin
    if (bus.we) begin
      store[bus.waddr] <= bus.wdata;
    end
  end

  assign bus.rdata = rdata_q;

endmodule : fsw_mem

// ### fsw_core.sv
// apb-mapped execution unit for the file-minus-working-register instruction
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/100ps
module fsw_core
  import fsw_pkg::*;
(
  input  wire logic                  CORE_CLK,
  input  wire logic                  RESET,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [APB_ADDR_W-1:0] PADDR,
  input  wire logic [APB_DATA_W-1:0] PWDATA,
  output logic      [APB_DATA_W-1:0] PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR
);

  fsw_alu_if alu_bus ();
  fsw_mem_if mem_bus ();

  fsw_alu u_alu (
    .bus (alu_bus)
  );

  fsw_mem #(
    .ADDR_W (LIN_ADDR_W),
    .WORD_W (DATA_W)
  ) u_mem (
    .CORE_CLK (CORE_CLK),
    .RESET    (RESET),
    .bus      (mem_bus)
  );

  fsw_state_e            state_q;
  fsw_state_e            state_d;
  logic [INSTR_W-1:0]    instr_q;
  logic [INSTR_W-1:0]    instr_d;
  logic [DATA_W-1:0]     work_q;
  logic [DATA_W-1:0]     work_d;
  logic [BANK_W-1:0]     bank_q;
  logic [BANK_W-1:0]     bank_d;
  logic [FLAG_W-1:0]     flags_q;
  logic [FLAG_W-1:0]     flags_d;
  logic                  illegal_q;
  logic                  illegal_d;
  logic [LIN_ADDR_W-1:0] faddr_q;
  logic [LIN_ADDR_W-1:0] faddr_d;
  logic [DATA_W-1:0]     result_q;
  logic [DATA_W-1:0]     result_d;
  logic [FLAG_W-1:0]     pend_flags_q;
  logic [FLAG_W-1:0]     pend_flags_d;
  logic [APB_DATA_W-1:0] prdata_d;
  logic                  pready_d;
  logic                  pslverr_d;

  logic                  busy;
  logic                  access;
  logic                  xfer;
  logic                  wr_ok;
  logic [OPC_W-1:0]      opcode;
  logic                  dest_sel;
  logic                  access_sel;
  logic [FADDR_W-1:0]    file_addr;
  logic [LIN_ADDR_W-1:0] lin_addr;
  logic                  known_reg;

  // instruction fields: one bit each for d and a, then the full file address
  always_comb begin
    opcode     = instr_q[OPC_HI:OPC_LO];
    dest_sel   = instr_q[DEST_BIT];
    access_sel = instr_q[ACCESS_BIT];
    file_addr  = instr_q[FADDR_HI:FADDR_LO];
  end

  // bank selection for the operand address
  always_comb begin
    if (access_sel == ACCESS_FIXED) begin
      if (file_addr < ACCESS_SPLIT) begin
        lin_addr = {ACCESS_LOW_BANK, file_addr};
      end else begin
        lin_addr = {ACCESS_HIGH_BANK, file_addr};
      end
    end else begin
      lin_addr = {bank_q, file_addr};
    end
  end

  // apb decode; the slave answers in the second access cycle
  always_comb begin
    busy     = (state_q != S_IDLE);
    access   = PSEL && PENABLE;
    xfer     = access && PREADY;
    wr_ok    = xfer && PWRITE && !PSLVERR;
    known_reg = (PADDR == OFS_INSTR) || (PADDR == OFS_WORK) || (PADDR == OFS_BANK) ||
                (PADDR == OFS_STATUS) || (PADDR == OFS_FILE_ADDR) || (PADDR == OFS_FILE_DATA) ||
                (PADDR == OFS_RESULT);
    pready_d  = access && !PREADY;
    pslverr_d = 1'b0;
    // read data stands only with the answer, zero in every other cycle
    prdata_d  = PRDATA_RST;
    if (access && !PREADY) begin
      // any write while executing is refused so software cannot race the datapath
      pslverr_d = !known_reg || (PWRITE && busy) || (PWRITE && (PADDR == OFS_RESULT)) ||
                  (!PWRITE && busy && (PADDR == OFS_FILE_DATA));
      prdata_d  = PRDATA_RST;
      if (!PWRITE) begin
        case (PADDR)
          OFS_INSTR:     prdata_d[INSTR_W-1:0]    = instr_q;
          OFS_WORK:      prdata_d[DATA_W-1:0]     = work_q;
          OFS_BANK:      prdata_d[BANK_W-1:0]     = bank_q;
          OFS_STATUS: begin
            prdata_d[FLAG_W-1:0] = flags_q;
            prdata_d[ST_BUSY]    = busy;
            prdata_d[ST_ILLEGAL] = illegal_q;
          end
          OFS_FILE_ADDR: prdata_d[LIN_ADDR_W-1:0] = faddr_q;
          OFS_FILE_DATA: prdata_d[DATA_W-1:0]     = busy ? 8'h00 : mem_bus.rdata;
          OFS_RESULT:    prdata_d[DATA_W-1:0]     = result_q;
          default:       prdata_d                 = PRDATA_RST;
        endcase
      end
    end
  end

  // sequencer and architectural state
  always_comb begin
    state_d      = state_q;
    instr_d      = instr_q;
    work_d       = work_q;
    bank_d       = bank_q;
    flags_d      = flags_q;
    illegal_d    = illegal_q;
    faddr_d      = faddr_q;
    result_d     = result_q;
    pend_flags_d = pend_flags_q;
    alu_bus.file_val = mem_bus.rdata;
    alu_bus.work_val = work_q;
    mem_bus.raddr    = faddr_q;
    mem_bus.we       = 1'b0;
    mem_bus.waddr    = faddr_q;
    mem_bus.wdata    = PWDATA[DATA_W-1:0];

    if (wr_ok) begin
      case (PADDR)
        OFS_INSTR: begin
          instr_d = PWDATA[INSTR_W-1:0];
          state_d = S_DECODE;
        end
        OFS_WORK:      work_d  = PWDATA[DATA_W-1:0];
        OFS_BANK:      bank_d  = PWDATA[BANK_W-1:0];
        OFS_STATUS: begin
          flags_d = PWDATA[FLAG_W-1:0];
          if (PWDATA[ST_ILLEGAL]) begin
            illegal_d = 1'b0;
          end
        end
        OFS_FILE_ADDR: faddr_d = PWDATA[LIN_ADDR_W-1:0];
        OFS_FILE_DATA: mem_bus.we = 1'b1;
        default: begin
        end
      endcase
    end

    case (state_q)
      S_IDLE: begin
      end
      S_DECODE: begin
        if (opcode == OPC_FILE_MINUS_ACC) begin
          state_d = S_READ;
        end else begin
          illegal_d = 1'b1;
          state_d   = S_IDLE;
        end
      end
      S_READ: begin
        mem_bus.raddr = lin_addr;
        state_d       = S_PROC;
      end
      S_PROC: begin
        result_d     = alu_bus.result;
        pend_flags_d = alu_bus.flags;
        state_d      = S_WRITE;
      end
      S_WRITE: begin
        flags_d = pend_flags_q;
        if (dest_sel == DEST_WORK) begin
          work_d = result_q;
        end else begin
          mem_bus.we    = 1'b1;
          mem_bus.waddr = lin_addr;
          mem_bus.wdata = result_q;
        end
        state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state_q      <= S_IDLE;
      instr_q      <= INSTR_RST;
      work_q       <= WORK_RST;
      bank_q       <= BANK_RST;
      flags_q      <= FLAGS_RST;
      illegal_q    <= 1'b0;
      faddr_q      <= FADDR_RST;
      result_q     <= WORK_RST;
      pend_flags_q <= FLAGS_RST;
      PRDATA       <= PRDATA_RST;
      PREADY       <= 1'b0;
      PSLVERR      <= 1'b0;
    end else begin
      state_q      <= state_d;
      instr_q      <= instr_d;
      work_q       <= work_d;
      bank_q       <= bank_d;
      flags_q      <= flags_d;
      illegal_q    <= illegal_d;
      faddr_q      <= faddr_d;
      result_q     <= result_d;
      pend_flags_q <= pend_flags_d;
      PRDATA       <= prdata_d;
      PREADY       <= pready_d;
      PSLVERR      <= pslverr_d;
    end
  end

endmodule : fsw_core

// ### fsw_core_note_end.sv
// intentionally empty compilation unit
`timescale 1ns/100ps

// ### fsw_core_props.sv
// concurrent checks on the apb ports of the subtract unit
`timescale 1ns/100ps
module fsw_core_props
  import fsw_pkg::*;
(
  input wire logic                  CORE_CLK,
  input wire logic                  RESET,
  input wire logic                  PSEL,
  input wire logic                  PENABLE,
  input wire logic                  PWRITE,
  input wire logic [APB_ADDR_W-1:0] PADDR,
  input wire logic [APB_DATA_W-1:0] PWDATA,
  input wire logic [APB_DATA_W-1:0] PRDATA,
  input wire logic                  PREADY,
  input wire logic                  PSLVERR
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  sequence first_access;
    PSEL && PENABLE && !PREADY;
  endsequence
  sequence answer;
    PSEL && PENABLE && PREADY;
  endsequence
  sequence rd_answer(logic [APB_ADDR_W-1:0] ofs);
    PREADY && !PWRITE && PADDR == ofs;
  endsequence

  chk_one_wait: assert property (first_access |=> answer)
    else $error("answer not one cycle after access");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready stood longer than one cycle");
  chk_ready_cause: assert property (PREADY |-> PSEL && PENABLE && $past(PENABLE))
    else $error("ready without a pending access");
  chk_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error flag outside an answer");
  chk_rdata_idle: assert property (!(PREADY && !PWRITE) |-> PRDATA == '0)
    else $error("read data not zero outside a read answer");
  chk_unmapped_err: assert property (answer ##0 (PADDR[1:0] != 2'h0 || PADDR > OFS_RESULT) |-> PSLVERR)
    else $error("unmapped access not refused");
  chk_result_ro: assert property (answer ##0 (PWRITE && PADDR == OFS_RESULT) |-> PSLVERR)
    else $error("write to result not refused");
  chk_work_narrow: assert property (rd_answer(OFS_WORK) |-> PRDATA[APB_DATA_W-1:DATA_W] == '0)
    else $error("working register upper bits not zero");
  chk_bank_narrow: assert property (rd_answer(OFS_BANK) |-> PRDATA[APB_DATA_W-1:BANK_W] == '0)
    else $error("bank pointer upper bits not zero");
endmodule : fsw_core_props

bind fsw_core fsw_core_props u_props (.CORE_CLK(CORE_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));

// ### tb.sv
// self-checking bench for the file-minus-working-register unit
`timescale 1ns/100ps
module tb;
  import fsw_pkg::*;
  logic                  core_clk   = 1'b0;
  logic                  reset      = 1'b1;
  logic                  psel       = 1'b0;
  logic                  penable    = 1'b0;
  logic                  pwrite     = 1'b0;
  logic [APB_ADDR_W-1:0] paddr      = 8'h00;
  logic [APB_DATA_W-1:0] pwdata     = 32'h0000_0000;
  logic [APB_DATA_W-1:0] prdata;
  logic                  pready;
  logic                  pslverr;
  logic [APB_DATA_W-1:0] rdata_seen;
  logic                  err_seen;
  int                    err_total  = 0;
  int                    n_compared = 0;

  always #2 core_clk = ~core_clk;

  fsw_core dut (.CORE_CLK(core_clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
                .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

  task automatic end_sim;
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // an idle cycle always precedes setup, so no signal is driven twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) cmp("pready", 32'h1, {31'h0, pready});
    rdata_seen = prdata;
    err_seen   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    cmp("write refused", 32'h0, {31'h0, err_seen});
  endtask : wr

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(what, exp, rdata_seen);
  endtask : rd

  task automatic exec(input logic [15:0] ins);
    int n;
    n = 0;
    wr(OFS_INSTR, {16'h0, ins});
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rdata_seen[ST_BUSY] !== 1'b0 && n < 8);
    cmp("busy", 32'h0, {31'h0, rdata_seen[ST_BUSY]});
  endtask : exec

  function automatic logic [4:0] flags_of(input logic [7:0] f, input logic [7:0] w);
    logic [7:0] r;
    r = f - w;
    flags_of[ST_CARRY]  = f >= w;
    flags_of[ST_NIBBLE] = f[3:0] >= w[3:0];
    flags_of[ST_ZERO]   = r == 8'h00;
    flags_of[ST_WRAP]   = (f[7] != w[7]) && (r[7] != f[7]);
    flags_of[ST_NEG]    = r[7];
  endfunction : flags_of

  task automatic t_reset;
    logic [7:0] ofs [5] = '{OFS_INSTR, OFS_WORK, OFS_BANK, OFS_STATUS, OFS_FILE_ADDR};
    foreach (ofs[i]) rd("reset value", ofs[i], 32'h0);
  endtask : t_reset

  // a decoy of the inverted value sits in the bank that must not be used
  task automatic t_sub(input logic [7:0] f, input logic [7:0] w, input logic d, input logic a,
                       input logic [3:0] bank, input logic [7:0] fa);
    logic [11:0] acc, bp, lin, alt;
    logic [7:0]  r;
    acc = {(fa < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, fa};
    bp  = {bank, fa};
    lin = a ? bp : acc;
    alt = a ? acc : bp;
    r   = f - w;
    wr(OFS_BANK, {28'h0, bank});
    wr(OFS_FILE_ADDR, {20'h0, alt});
    wr(OFS_FILE_DATA, {24'h0, ~f});
    wr(OFS_FILE_ADDR, {20'h0, lin});
    wr(OFS_FILE_DATA, {24'h0, f});
    wr(OFS_WORK, {24'h0, w});
    exec({OPC_FILE_MINUS_ACC, d, a, fa});
    cmp("flags", {27'h0, flags_of(f, w)}, rdata_seen);
    rd("result", OFS_RESULT, {24'h0, r});
    rd("work", OFS_WORK, {24'h0, d ? w : r});
    rd("file", OFS_FILE_DATA, {24'h0, d ? r : f});
    wr(OFS_FILE_ADDR, {20'h0, alt});
    rd("other bank", OFS_FILE_DATA, {24'h0, ~f});
  endtask : t_sub

  task automatic t_refuse;
    apb(1'b1, 8'h1c, 32'h0000_00ff);
    cmp("unmapped write", 32'h1, {31'h0, err_seen});
    apb(1'b0, 8'h05, 32'h0);
    cmp("misaligned read", 32'h1, {31'h0, err_seen});
    apb(1'b1, OFS_RESULT, 32'h0000_0033);
    cmp("result write", 32'h1, {31'h0, err_seen});
    rd("result kept", OFS_RESULT, 32'h0000_00ff);
  endtask : t_refuse

  task automatic t_illegal;
    logic [5:0] bad [3] = '{6'h16, 6'h1f, 6'h37};
    wr(OFS_WORK, 32'h0000_005a);
    wr(OFS_STATUS, 32'h0);
    foreach (bad[i]) begin
      exec({bad[i], 2'b00, 8'h10});
      cmp("illegal flag", 32'h1 << ST_ILLEGAL, rdata_seen);
      rd("work kept", OFS_WORK, 32'h0000_005a);
      wr(OFS_STATUS, 32'h1 << ST_ILLEGAL);
      rd("flag cleared", OFS_STATUS, 32'h0);
    end
  endtask : t_illegal

  // a write that lands while the instruction runs is refused and leaves no trace
  task automatic t_busy;
    wr(OFS_FILE_ADDR, 32'h0000_0010);
    wr(OFS_FILE_DATA, 32'h0000_0040);
    wr(OFS_WORK, 32'h0000_0011);
    wr(OFS_INSTR, {16'h0, OPC_FILE_MINUS_ACC, DEST_WORK, ACCESS_FIXED, 8'h10});
    apb(1'b1, OFS_WORK, 32'h0000_0022);
    cmp("busy write", 32'h1, {31'h0, err_seen});
    rd("work after busy", OFS_WORK, 32'h0000_002f);
  endtask : t_busy

  initial begin
    #100000;
    err_total++;
    end_sim();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_sub(8'h03, 8'h02, 1'b1, 1'b0, 4'h5, 8'h10);
    t_sub(8'h02, 8'h02, 1'b0, 1'b0, 4'h5, 8'h20);
    t_sub(8'h01, 8'h02, 1'b1, 1'b0, 4'h5, 8'h7f);
    t_sub(8'h80, 8'h01, 1'b0, 1'b0, 4'h5, 8'h80);
    t_sub(8'h10, 8'h01, 1'b1, 1'b1, 4'h3, 8'h44);
    t_sub(8'h00, 8'hff, 1'b1, 1'b1, 4'he, 8'hff);
    t_sub(8'h7f, 8'h80, 1'b0, 1'b1, 4'h1, 8'h00);
    t_refuse();
    t_illegal();
    t_busy();
    end_sim();
  end
endmodule : tb
